// [alarm_level_steering.v]
/*
 * Alarm and level-steering threshold logic with an APB register slave.
 * Assumes: one clock clk, synchronous active-high rst; update_strobe pulses
 * once per output update cycle with fresh conditioning-chain samples.
 */
// Implementation choice: the APB slave port.
`timescale 1ns/1ns
`include "alarm_level_defines.vh"

module alarm_level_steering #(
    parameter W = 8
) (
    input  wire         clk,
    input  wire         rst,
    input  wire         psel,
    input  wire         penable,
    input  wire         pwrite,
    input  wire [31:0]  paddr,
    input  wire [31:0]  pwdata,
    output wire [31:0]  prdata,
    output wire         pready,
    output wire         pslverr,
    input  wire         update_strobe,
    input  wire [W-1:0] temp_amp_output,
    input  wire [W-1:0] input_amp_output,
    input  wire [W-1:0] gain_node_output,
    input  wire [W-1:0] voltage_mode_output,
    input  wire [W-1:0] computed_output_value,
    input  wire         line_low_in,
    input  wire         line_high_in,
    output wire [W-1:0] digital_output_value,
    output wire         alarm,
    output wire         level_line_low,
    output wire         level_line_high,
    output wire         irq
);
    reg  [7:0]            sel_q;
    reg  [W-1:0]          lvl1_q;
    reg  [W-1:0]          lvl2_q;
    reg  [W-1:0]          lvl3_q;
    reg  [W-1:0]          hsub_q;
    reg  [`MODE_WIDTH-1:0] mode_q;
    reg  [`EV_WIDTH-1:0]  ev_status_q;
    reg  [`EV_WIDTH-1:0]  ev_status_d;
    reg  [`EV_WIDTH-1:0]  ev_mask_q;
    reg  [31:0]           prdata_q;
    reg                   pready_q;
    reg                   pslverr_q;
    reg                   irq_q;
    reg  [W-1:0]          dout_q;
    reg                   alarm_q;
    reg                   alarm_low_q;
    reg                   alarm_high_q;
    reg  [1:0]            code_q;
    reg  [31:0]           rd_word;
    reg                   rd_hit;

    wire [7:0]   idx = paddr[`ADDR_IDX_HI:`ADDR_IDX_LO];
    wire         setup = psel & ~penable;
    wire         wr_en = psel & penable & pready_q & pwrite;
    wire [W-1:0] alarm_sample;
    wire [W-1:0] level_sample;
    wire [1:0]   level_code;

    // level steering dominates; dual output mode kills the alarm
    wire level_mode = mode_q[`MODE_LEVEL_EN];
    wire dual_out   = mode_q[`MODE_CURRENT_EN] & mode_q[`MODE_VOLTAGE_EN];
    wire alarm_mode = mode_q[`MODE_ALARM_EN] & ~level_mode & ~dual_out;

    // alarm source from the three top bits
    signal_select #(.W(W)) u_alarm_sel (
        .sel                 (sel_q[`ALARM_SEL_HI:`ALARM_SEL_LO]),
        .temp_amp_output     (temp_amp_output),
        .input_amp_output    (input_amp_output),
        .gain_node_output    (gain_node_output),
        .voltage_mode_output (voltage_mode_output),
        .line_low_in         (line_low_in),
        .line_high_in        (line_high_in),
        .selected            (alarm_sample)
    );

    // level source: two bits, top select bit forced low to stay in range
    signal_select #(.W(W)) u_level_sel (
        .sel                 ({1'b0, sel_q[`LEVEL_SEL_HI:`LEVEL_SEL_LO]}),
        .temp_amp_output     (temp_amp_output),
        .input_amp_output    (input_amp_output),
        .gain_node_output    (gain_node_output),
        .voltage_mode_output (voltage_mode_output),
        .line_low_in         (line_low_in),
        .line_high_in        (line_high_in),
        .selected            (level_sample)
    );

    // same three bytes reinterpreted as ascending boundaries
    level_encoder #(.W(W)) u_levels (
        .sample (level_sample),
        .levels ({lvl3_q, lvl2_q, lvl1_q}),
        .code   (level_code)
    );

    wire low_hit  = alarm_mode & (alarm_sample < lvl1_q);
    wire high_hit = alarm_mode & (alarm_sample > lvl3_q);

    // evaluation only on the update strobe so outputs hold between updates
    always @(posedge clk) begin
        if (rst) begin
            dout_q       <= {W{1'b0}};
            alarm_q      <= 1'b0;
            alarm_low_q  <= 1'b0;
            alarm_high_q <= 1'b0;
            code_q       <= 2'b00;
        end else if (update_strobe) begin
            alarm_low_q  <= low_hit;
            alarm_high_q <= high_hit;
            alarm_q      <= low_hit | high_hit;
            if (low_hit) begin
                dout_q <= lvl2_q;
            end else if (high_hit) begin
                dout_q <= hsub_q;
            end else begin
                dout_q <= computed_output_value;
            end
            if (level_mode) begin
                code_q <= level_code;
            end else begin
                code_q <= 2'b00;
            end
        end
    end

    // sticky events; a new event beats a same-cycle write-one clear
    always @* begin
        ev_status_d = ev_status_q;
        if (wr_en && idx == `IDX_EVENT_STATUS) begin
            ev_status_d = ev_status_q & ~pwdata[`EV_WIDTH-1:0];
        end
        if (update_strobe) begin
            if (low_hit & ~alarm_low_q) begin
                ev_status_d[`EV_ALARM_LOW] = 1'b1;
            end
            if (high_hit & ~alarm_high_q) begin
                ev_status_d[`EV_ALARM_HIGH] = 1'b1;
            end
            if (level_mode && level_code != code_q) begin
                ev_status_d[`EV_LEVEL_CHANGE] = 1'b1;
            end
        end
    end

    always @* begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        case (idx)
            `IDX_THRESHOLD_INPUT_SELECT:      rd_word[7:0] = sel_q;
            `IDX_LOW_TRIGGER_OR_LEVEL_ONE:    rd_word[W-1:0] = lvl1_q;
            `IDX_LOW_SUBSTITUTE_OR_LEVEL_TWO: rd_word[W-1:0] = lvl2_q;
            `IDX_HIGH_TRIGGER_OR_LEVEL_THREE: rd_word[W-1:0] = lvl3_q;
            `IDX_HIGH_SUBSTITUTE_LEVEL:       rd_word[W-1:0] = hsub_q;
            `IDX_MODE_CONTROL:                rd_word[`MODE_WIDTH-1:0] = mode_q;
            `IDX_EVENT_STATUS:                rd_word[`EV_WIDTH-1:0] = ev_status_q;
            `IDX_EVENT_MASK:                  rd_word[`EV_WIDTH-1:0] = ev_mask_q;
            `IDX_BLOCK_STATUS: begin
                rd_word[`ST_ALARM]      = alarm_q;
                rd_word[`ST_ALARM_LOW]  = alarm_low_q;
                rd_word[`ST_ALARM_HIGH] = alarm_high_q;
                rd_word[`ST_LINE_LOW]   = code_q[0];
                rd_word[`ST_LINE_HIGH]  = code_q[1];
                rd_word[`ST_MODE_LEVEL] = level_mode;
                rd_word[`ST_MODE_ALARM] = alarm_mode;
                rd_word[`ST_OUT_LO +: W] = dout_q;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    // one wait-free access phase: answer prepared at the setup edge
    always @(posedge clk) begin
        if (rst) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup & ~rd_hit;
            if (setup && !pwrite) begin
                prdata_q <= rd_word;
            end
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            sel_q       <= `RESET_BYTE;
            lvl1_q      <= {W{1'b0}};
            lvl2_q      <= {W{1'b0}};
            lvl3_q      <= {W{1'b0}};
            hsub_q      <= {W{1'b0}};
            mode_q      <= `RESET_MODE;
            ev_mask_q   <= `RESET_EVENTS;
            ev_status_q <= `RESET_EVENTS;
            irq_q       <= 1'b0;
        end else begin
            ev_status_q <= ev_status_d;
            irq_q       <= |(ev_status_d & ev_mask_q);
            if (wr_en) begin
                case (idx)
                    `IDX_THRESHOLD_INPUT_SELECT:      sel_q <= pwdata[7:0];
                    `IDX_LOW_TRIGGER_OR_LEVEL_ONE:    lvl1_q <= pwdata[W-1:0];
                    `IDX_LOW_SUBSTITUTE_OR_LEVEL_TWO: lvl2_q <= pwdata[W-1:0];
                    `IDX_HIGH_TRIGGER_OR_LEVEL_THREE: lvl3_q <= pwdata[W-1:0];
                    `IDX_HIGH_SUBSTITUTE_LEVEL:       hsub_q <= pwdata[W-1:0];
                    `IDX_MODE_CONTROL:    mode_q <= pwdata[`MODE_WIDTH-1:0];
                    `IDX_EVENT_MASK:      ev_mask_q <= pwdata[`EV_WIDTH-1:0];
                    default: ;
                endcase
            end
        end
    end

    assign prdata               = prdata_q;
    assign pready               = pready_q;
    assign pslverr              = pslverr_q;
    assign irq                  = irq_q;
    assign digital_output_value = dout_q;
    assign alarm                = alarm_q;
    assign level_line_low       = code_q[0];
    assign level_line_high      = code_q[1];
endmodule // alarm_level_steering

// [alarm_level_defines.vh]
/*
 * Register indices, field positions, reset values and source codes for the
 * alarm / level-steering threshold block.
 * Assumes: included by bare name; byte address of a register is 4 * index.
 */
`ifndef ALARM_LEVEL_DEFINES_VH
`define ALARM_LEVEL_DEFINES_VH

// register indices (byte address = index * 4)
`define IDX_THRESHOLD_INPUT_SELECT      8'h1E
`define IDX_LOW_TRIGGER_OR_LEVEL_ONE    8'h1F
`define IDX_LOW_SUBSTITUTE_OR_LEVEL_TWO 8'h20
`define IDX_HIGH_TRIGGER_OR_LEVEL_THREE 8'h21
`define IDX_HIGH_SUBSTITUTE_LEVEL       8'h22
`define IDX_MODE_CONTROL                8'h10
`define IDX_EVENT_STATUS                8'h11
`define IDX_EVENT_MASK                  8'h12
`define IDX_BLOCK_STATUS                8'h13

// byte address bits that carry the index
`define ADDR_IDX_HI 9
`define ADDR_IDX_LO 2

// threshold_input_select fields
`define ALARM_SEL_HI 7
`define ALARM_SEL_LO 5
`define LEVEL_SEL_HI 6
`define LEVEL_SEL_LO 5

// mode_control fields
`define MODE_ALARM_EN   0
`define MODE_LEVEL_EN   1
`define MODE_CURRENT_EN 2
`define MODE_VOLTAGE_EN 3
`define MODE_WIDTH      4

// event bits
`define EV_ALARM_LOW    0
`define EV_ALARM_HIGH   1
`define EV_LEVEL_CHANGE 2
`define EV_WIDTH        3

// block_status fields
`define ST_ALARM        0
`define ST_ALARM_LOW    1
`define ST_ALARM_HIGH   2
`define ST_LINE_LOW     3
`define ST_LINE_HIGH    4
`define ST_MODE_LEVEL   5
`define ST_MODE_ALARM   6
`define ST_OUT_LO       8

// source codes
`define SRC_TEMP_AMP    3'h0
`define SRC_INPUT_AMP   3'h1
`define SRC_GAIN_NODE   3'h2
`define SRC_VOLT_MODE   3'h3
`define SRC_LINE_LOW    3'h4
`define SRC_LINE_HIGH   3'h5

`define RESET_BYTE      8'h00
`define RESET_MODE      4'h0
`define RESET_EVENTS    3'h0

`endif

// [signal_select.v]
/*
 * Source selector for a threshold comparison.
 * Assumes: all analog-chain samples are already digital and synchronous to clk.
 */
`timescale 1ns/1ns
`include "alarm_level_defines.vh"

module signal_select #(
    parameter W = 8
) (
    input  wire [2:0]   sel,
    input  wire [W-1:0] temp_amp_output,
    input  wire [W-1:0] input_amp_output,
    input  wire [W-1:0] gain_node_output,
    input  wire [W-1:0] voltage_mode_output,
    input  wire         line_low_in,
    input  wire         line_high_in,
    output reg  [W-1:0] selected
);
    // digital lines compare as full-scale or zero
    always @* begin
        case (sel)
            `SRC_TEMP_AMP:  selected = temp_amp_output;
            `SRC_INPUT_AMP: selected = input_amp_output;
            `SRC_GAIN_NODE: selected = gain_node_output;
            `SRC_VOLT_MODE: selected = voltage_mode_output;
            `SRC_LINE_LOW:  selected = {W{line_low_in}};
            `SRC_LINE_HIGH: selected = {W{line_high_in}};
            default:        selected = temp_amp_output;
        endcase
    end
endmodule // signal_select

// [level_encoder.v]
/*
 * Three-boundary encoder: counts how many levels the sample has reached.
 * Assumes: levels are ascending; result is the two-line code {high, low}.
 */
`timescale 1ns/1ns

module level_encoder #(
    parameter W = 8
) (
    input  wire [W-1:0]   sample,
    input  wire [3*W-1:0] levels,
    output wire [1:0]     code
);
    wire [2:0] reached;

    genvar i;
    generate
        for (i = 0; i < 3; i = i + 1) begin : g_cmp
            // reaching a level counts as crossing it
            assign reached[i] = (sample >= levels[i*W +: W]);
        end
    endgenerate

    assign code = {1'b0, reached[0]} + {1'b0, reached[1]} + {1'b0, reached[2]};
endmodule // level_encoder

// [sample_source.sv]
/* Conditioning-chain model feeding samples and one strobe per update.
   Assumes: go is a one-cycle request from the bench, synchronous to clk. */
`timescale 1ns/1ns
module sample_source (
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic [2:0] src,
    input  wire logic [7:0] value,
    output logic      [7:0] temp_amp_output,
    output logic      [7:0] input_amp_output,
    output logic      [7:0] gain_node_output,
    output logic      [7:0] voltage_mode_output,
    output logic      [7:0] computed_output_value,
    output logic            line_low_in,
    output logic            line_high_in,
    output logic            update_strobe
);
    initial begin
        {temp_amp_output, input_amp_output, gain_node_output} = 24'h808080;
        {voltage_mode_output, computed_output_value} = 16'h8000;
        {line_low_in, line_high_in, update_strobe} = 3'h0;
    end
    // unselected amplifier sources sit mid-scale and unselected lines low so a wrong selector shows up
    always @(posedge clk) begin
        update_strobe <= go;
        if (go) begin
            temp_amp_output       <= (src == 3'h0) ? value : 8'h80;
            input_amp_output      <= (src == 3'h1) ? value : 8'h80;
            gain_node_output      <= (src == 3'h2) ? value : 8'h80;
            voltage_mode_output   <= (src == 3'h3) ? value : 8'h80;
            line_low_in           <= (src == 3'h4) ? value[7] : 1'b0;
            line_high_in          <= (src == 3'h5) ? value[7] : 1'b0;
            computed_output_value <= value ^ 8'h5A;
        end
    end
endmodule // sample_source

// [alarm_level_chk.sv]
/* Port-level checker for alarm_level_steering.
   Assumes: bound to the top module; one clock, synchronous reset. */
`timescale 1ns/1ns
module alarm_level_chk #(
    parameter W = 8
) (
    input wire logic         clk,
    input wire logic         rst,
    input wire logic         psel,
    input wire logic         penable,
    input wire logic [31:0]  prdata,
    input wire logic         pready,
    input wire logic         pslverr,
    input wire logic         update_strobe,
    input wire logic [W-1:0] computed_output_value,
    input wire logic [W-1:0] digital_output_value,
    input wire logic         alarm,
    input wire logic         level_line_low,
    input wire logic         level_line_high
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence apb_setup;
        psel && !penable;
    endsequence
    sequence apb_access;
        psel && penable && pready;
    endsequence
    apb_answer_a: assert property (apb_setup |=> apb_access)
        else $error("no answer after setup");
    ready_in_access_a: assert property (pready |-> psel && penable && $past(psel && !penable))
        else $error("ready outside access");
    ready_one_cycle_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    error_data_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error without ready or with data");
    read_upper_zero_a: assert property (pready |-> prdata[31:16] == 16'h0)
        else $error("upper read bits set");
    hold_no_strobe_a: assert property (
        !update_strobe |=> $stable({digital_output_value, alarm, level_line_low, level_line_high}))
        else $error("outputs moved without strobe");
    pass_through_a: assert property (
        update_strobe |=> alarm || digital_output_value == $past(computed_output_value))
        else $error("output not passed through");
    alarm_no_code_a: assert property (
        alarm |-> !level_line_low && !level_line_high)
        else $error("alarm together with level code");
endmodule // alarm_level_chk
bind alarm_level_steering alarm_level_chk #(.W(W)) i_alarm_level_chk (.*);

// [alarm_level_steering_tb_top.sv]
/* Testbench: APB register tasks plus sample sequences with expected values.
   Assumes sample_source as the far side and the bound checker. */
`timescale 1ns/1ns
`include "alarm_level_defines.vh"
module alarm_level_steering_tb_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic        go = 1'b0;
    logic [2:0]  src = 3'h0;
    logic [7:0]  value = 8'h00;
    logic [31:0] rd;
    logic        err;
    wire  [31:0] prdata;
    wire         pready, pslverr, upd, line_lo, line_hi, alarm, lvl_lo, lvl_hi, irq;
    wire  [7:0]  t_o, i_o, g_o, v_o, c_o, dov;
    int          fail_count = 0;
    int          checks_done = 0;
    always #10 clk = ~clk;

    alarm_level_steering #(.W(8)) i_alarm_level_steering (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .update_strobe(upd), .temp_amp_output(t_o),
        .input_amp_output(i_o), .gain_node_output(g_o), .voltage_mode_output(v_o),
        .computed_output_value(c_o), .line_low_in(line_lo), .line_high_in(line_hi),
        .digital_output_value(dov), .alarm(alarm), .level_line_low(lvl_lo),
        .level_line_high(lvl_hi), .irq(irq));
    sample_source i_sample_source (
        .clk(clk), .go(go), .src(src), .value(value), .temp_amp_output(t_o),
        .input_amp_output(i_o), .gain_node_output(g_o), .voltage_mode_output(v_o),
        .computed_output_value(c_o), .line_low_in(line_lo), .line_high_in(line_hi),
        .update_strobe(upd));

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {22'h0, idx, 2'h0};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            fail_count++;
            report_and_stop();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp, input string name);
        apb(1'b0, idx, 32'h0);
        chk(name, rd, exp);
    endtask
    // levels fixed at 40/80/C0, high substitute EE for every sample
    task automatic smp(input logic [2:0] s_src, input logic [7:0] v, input logic [3:0] mode);
        logic [7:0] s;
        logic       lvl, al, lo, hi;
        logic [1:0] code;
        // mode register must match what the expectation assumes
        apb(1'b1, `IDX_MODE_CONTROL, {28'h0, mode});
        s = (s_src > 3'h3) ? {8{v[7]}} : v;
        lvl = mode[`MODE_LEVEL_EN];
        al = mode[`MODE_ALARM_EN] && !lvl && !(mode[2] && mode[3]);
        lo = al && s < 8'h40;
        hi = al && s > 8'hC0;
        code = {1'b0, s >= 8'h40} + {1'b0, s >= 8'h80} + {1'b0, s >= 8'hC0};
        src <= s_src;
        value <= v;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (2) @(posedge clk);
        chk("alarm", alarm, lo | hi);
        chk("code", {lvl_hi, lvl_lo}, lvl ? code : 2'h0);
        chk("out", dov, lo ? 8'h80 : hi ? 8'hEE : v ^ 8'h5A);
    endtask

    initial begin
        logic [7:0] regs [9] = '{8'h1E, 8'h1F, 8'h20, 8'h21, 8'h22, 8'h10, 8'h11, 8'h12, 8'h13};
        logic [7:0] av [6] = '{8'h00, 8'h3F, 8'h40, 8'hC0, 8'hC1, 8'hFF};
        logic [7:0] lv [7] = '{8'h3F, 8'h40, 8'h7F, 8'h80, 8'hBF, 8'hC0, 8'hFF};
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        foreach (regs[i]) rdchk(regs[i], 32'h0, "reset value");
        apb(1'b0, 8'h05, 32'hFFFF_FFFF);
        chk("unmapped err", err, 1'b1);
        chk("unmapped data", rd, 32'h0);
        apb(1'b1, `IDX_LOW_TRIGGER_OR_LEVEL_ONE, 32'h40);
        apb(1'b1, `IDX_LOW_SUBSTITUTE_OR_LEVEL_TWO, 32'h80);
        apb(1'b1, `IDX_HIGH_TRIGGER_OR_LEVEL_THREE, 32'hC0);
        apb(1'b1, `IDX_HIGH_SUBSTITUTE_LEVEL, 32'hEE);
        apb(1'b1, `IDX_MODE_CONTROL, 32'h1);
        rdchk(`IDX_HIGH_SUBSTITUTE_LEVEL, 32'hEE, "readback");
        $display("test registers done");
        smp(3'h0, 8'h80, 4'h1);
        apb(1'b1, `IDX_EVENT_STATUS, 32'h7);
        smp(3'h0, 8'h10, 4'h1);
        chk("irq masked", irq, 1'b0);
        rdchk(`IDX_EVENT_STATUS, 32'h1, "event");
        rdchk(`IDX_BLOCK_STATUS, 32'h8043, "status");
        apb(1'b1, `IDX_EVENT_MASK, 32'h1);
        @(posedge clk);
        chk("irq set", irq, 1'b1);
        apb(1'b1, `IDX_EVENT_STATUS, 32'h1);
        @(posedge clk);
        chk("irq clear", irq, 1'b0);
        $display("test interrupt done");
        for (int s = 0; s < 6; s++) begin
            apb(1'b1, `IDX_THRESHOLD_INPUT_SELECT, {24'h0, 3'(s), 5'h0});
            foreach (av[j]) smp(3'(s), av[j], 4'h1);
        end
        // back to the temperature source before the dual-output case
        apb(1'b1, `IDX_THRESHOLD_INPUT_SELECT, 32'h0);
        smp(3'h0, 8'h00, 4'hD);
        smp(3'h0, 8'hFF, 4'h0);
        $display("test alarm done");
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, `IDX_THRESHOLD_INPUT_SELECT, {25'h0, 2'(s), 5'h0});
            foreach (lv[j]) smp(3'(s), lv[j], 4'h3);
        end
        $display("test level done");
        report_and_stop();
    end
endmodule // alarm_level_steering_tb_top
